// ===== cam_pkg.sv
package cam_pkg;
    // bus geometry
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    // register byte offsets
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_LANE = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_SUMMARY = 8'h0c;
    localparam logic [7:0] OFF_CTRL = 8'h10;
    // alarm status bit positions
    localparam int unsigned BIT_FIFO = 0;
    localparam int unsigned BIT_PLL = 1;
    localparam int unsigned BIT_LINK = 2;
    localparam int unsigned BIT_SYSREF = 3;
    localparam int unsigned BIT_NCO = 4;
    localparam int unsigned BIT_CLK = 5;
    localparam int unsigned ALARM_W = 6;
    // control bit positions
    localparam int unsigned CTL_LINK_EN = 0;
    localparam int unsigned CTL_PIN_SEL = 1;
    localparam int unsigned CTL_AUTO_REINIT = 2;
    localparam int unsigned CTL_NCO_SYNC_SEL = 3;
    localparam int unsigned CTL_CHAN_A_OFF = 4;
    localparam int unsigned CTL_CHAN_B_OFF = 5;
    localparam int unsigned CTRL_W = 6;
    // summary bit position
    localparam int unsigned SUM_BIT = 0;
    // reset values
    localparam logic [ALARM_W-1:0] MASK_RST = 6'h00;
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
    // reinitialisation hold length in clock cycles
    localparam logic [2:0] REINIT_CYCLES = 3'h4;
    // bus answer states
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } cam_bus_state_t;
    // auto reinitialisation states
    typedef enum logic [1:0] {
        RI_IDLE = 2'b00,
        RI_HOLD = 2'b01,
        RI_RELEASE = 2'b11
    } cam_reinit_state_t;
endpackage

// ===== cam_sticky_bits.sv
`timescale 1ns/100ps
`default_nettype none
module cam_sticky_bits #(
    parameter int unsigned WIDTH = 6
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // set and clear
    input wire logic [WIDTH-1:0] set_vec,
    input wire logic [WIDTH-1:0] clr_vec,
    // flags
    output logic [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    // a set in the clearing cycle wins
    assign flags_next = (flags_reg & ~clr_vec) | set_vec;

    // sticky storage
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;
endmodule
`default_nettype wire

// ===== cam_chan_compare.sv
`timescale 1ns/100ps
`default_nettype none
module cam_chan_compare #(
    parameter int unsigned WIDTH = 32
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // compared values
    input wire logic enable,
    input wire logic [WIDTH-1:0] chan_a,
    input wire logic [WIDTH-1:0] chan_b,
    // result
    output logic mismatch
);
    logic mismatch_reg;

    // one differing sample is enough
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mismatch_reg <= 1'b0;
        end else begin
            mismatch_reg <= enable && (chan_a != chan_b);
        end
    end

    assign mismatch = mismatch_reg;
endmodule
`default_nettype wire

// ===== cam_monitor.sv
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module cam_monitor #(
    parameter int unsigned LANES = 16,
    parameter int unsigned NCO_W = 32,
    parameter int unsigned CLK_W = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // avalon-mm slave
    input wire logic [cam_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [cam_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [cam_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // alarm sources
    input wire logic [LANES-1:0] fifo_overflow_lane,
    input wire logic [LANES-1:0] fifo_underflow_lane,
    input wire logic serdes_pll_locked,
    input wire logic link_in_data_state,
    input wire logic sysref_realign,
    input wire logic sysref_event,
    input wire logic lane_align_start,
    input wire logic power_down_pin,
    // channel comparison inputs
    input wire logic [NCO_W-1:0] chan_a_nco_acc,
    input wire logic [NCO_W-1:0] chan_b_nco_acc,
    input wire logic [CLK_W-1:0] chan_a_clocks,
    input wire logic [CLK_W-1:0] chan_b_clocks,
    input wire logic half_rate_tick,
    input wire logic calibration_status,
    // pin and link control
    output logic status_output_pin,
    output logic link_reset_n,
    output logic serializer_power_down,
    output logic link_clock_enable,
    output logic link_reinit
);
    localparam int unsigned DW = cam_pkg::DATA_W;
    localparam int unsigned AW = cam_pkg::ALARM_W;

    // byte enables widened to a bit mask
    function automatic logic [DW-1:0] lane_mask(input logic [3:0] be);
        logic [DW-1:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    // address match
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    cam_pkg::cam_bus_state_t bus_state_reg;
    cam_pkg::cam_reinit_state_t ri_state_reg;
    cam_pkg::cam_reinit_state_t ri_state_next;
    logic [DW-1:0] readdata_reg;
    logic [DW-1:0] readdata_next;
    logic waitrequest_reg;
    logic [AW-1:0] mask_reg;
    logic [cam_pkg::CTRL_W-1:0] ctrl_reg;
    logic summary_reg;
    logic pin_reg;
    logic link_reset_n_reg;
    logic ser_pd_reg;
    logic link_clk_en_reg;
    logic reinit_reg;
    logic nco_synced_reg;
    logic [2:0] ri_cnt_reg;
    logic wr_go;
    logic [DW-1:0] wmask;
    logic [DW-1:0] wbits;
    logic [AW-1:0] status_clr;
    logic [LANES-1:0] lane_clr;
    logic [AW-1:0] events;
    logic [LANES-1:0] lane_events;
    logic [AW-1:0] status_bits;
    logic [LANES-1:0] lane_bits;
    logic nco_mismatch;
    logic clk_mismatch;
    logic link_en;
    logic both_on;
    logic nco_cmp_en;
    logic clk_cmp_en;

    assign link_en = ctrl_reg[cam_pkg::CTL_LINK_EN];
    assign both_on = !ctrl_reg[cam_pkg::CTL_CHAN_A_OFF] && !ctrl_reg[cam_pkg::CTL_CHAN_B_OFF];

    // bus answer: one wait cycle, then the slot where the master samples
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bus_state_reg <= cam_pkg::BUS_IDLE;
            waitrequest_reg <= 1'b1;
            readdata_reg <= '0;
        end else begin
            case (bus_state_reg)
                cam_pkg::BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state_reg <= cam_pkg::BUS_ACK;
                        waitrequest_reg <= 1'b0;
                        readdata_reg <= readdata_next;
                    end
                end
                default: begin
                    bus_state_reg <= cam_pkg::BUS_IDLE;
                    waitrequest_reg <= 1'b1;
                end
            endcase
        end
    end

    // write strobes and write-one-to-clear vectors
    assign wr_go = avs_write && (bus_state_reg == cam_pkg::BUS_ACK);
    assign wmask = lane_mask(avs_byteenable);
    assign wbits = avs_writedata & wmask;
    assign status_clr = (wr_go && addr_is(avs_address, cam_pkg::OFF_STATUS)) ?
        wbits[AW-1:0] : '0;
    assign lane_clr = (wr_go && addr_is(avs_address, cam_pkg::OFF_LANE)) ?
        wbits[LANES-1:0] : '0;

    // read decode
    always_comb begin
        readdata_next = '0;
        if (addr_is(avs_address, cam_pkg::OFF_STATUS)) begin
            readdata_next[AW-1:0] = status_bits;
        end else if (addr_is(avs_address, cam_pkg::OFF_LANE)) begin
            readdata_next[LANES-1:0] = lane_bits;
        end else if (addr_is(avs_address, cam_pkg::OFF_MASK)) begin
            readdata_next[AW-1:0] = mask_reg;
        end else if (addr_is(avs_address, cam_pkg::OFF_SUMMARY)) begin
            readdata_next[cam_pkg::SUM_BIT] = summary_reg;
        end else if (addr_is(avs_address, cam_pkg::OFF_CTRL)) begin
            readdata_next[cam_pkg::CTRL_W-1:0] = ctrl_reg;
        end
    end

    // mask and control registers, byte-lane aware
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mask_reg <= cam_pkg::MASK_RST;
            ctrl_reg <= cam_pkg::CTRL_RST;
        end else if (wr_go && addr_is(avs_address, cam_pkg::OFF_MASK)) begin
            mask_reg <= (mask_reg & ~wmask[AW-1:0]) | wbits[AW-1:0];
        end else if (wr_go && addr_is(avs_address, cam_pkg::OFF_CTRL)) begin
            ctrl_reg <= (ctrl_reg & ~wmask[cam_pkg::CTRL_W-1:0])
                | wbits[cam_pkg::CTRL_W-1:0];
        end
    end

    // oscillator check armed by the selected synchronisation event
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            nco_synced_reg <= 1'b0;
        end else if (!link_en || power_down_pin) begin
            nco_synced_reg <= 1'b0;
        end else if (ctrl_reg[cam_pkg::CTL_NCO_SYNC_SEL] ? lane_align_start : sysref_event) begin
            nco_synced_reg <= 1'b1;
        end
    end

    assign nco_cmp_en = nco_synced_reg && both_on;
    // clocks compared once per half-rate cycle while powered up
    assign clk_cmp_en = half_rate_tick && link_en && both_on && !power_down_pin;

    cam_chan_compare #(
        .WIDTH(NCO_W)
    ) u_nco_cmp (
        .clock(clock),
        .nrst(nrst),
        .enable(nco_cmp_en),
        .chan_a(chan_a_nco_acc),
        .chan_b(chan_b_nco_acc),
        .mismatch(nco_mismatch)
    );

    cam_chan_compare #(
        .WIDTH(CLK_W)
    ) u_clk_cmp (
        .clock(clock),
        .nrst(nrst),
        .enable(clk_cmp_en),
        .chan_a(chan_a_clocks),
        .chan_b(chan_b_clocks),
        .mismatch(clk_mismatch)
    );

    // alarm events, one bit per cause
    assign lane_events = fifo_overflow_lane | fifo_underflow_lane;
    assign events[cam_pkg::BIT_FIFO] = |lane_events;
    assign events[cam_pkg::BIT_PLL] = !serdes_pll_locked;
    assign events[cam_pkg::BIT_LINK] = link_en && !link_in_data_state;
    assign events[cam_pkg::BIT_SYSREF] = sysref_realign;
    assign events[cam_pkg::BIT_NCO] = nco_mismatch;
    assign events[cam_pkg::BIT_CLK] = clk_mismatch;

    cam_sticky_bits #(
        .WIDTH(AW)
    ) u_status (
        .clock(clock),
        .nrst(nrst),
        .set_vec(events),
        .clr_vec(status_clr),
        .flags(status_bits)
    );

    cam_sticky_bits #(
        .WIDTH(LANES)
    ) u_lanes (
        .clock(clock),
        .nrst(nrst),
        .set_vec(lane_events),
        .clr_vec(lane_clr),
        .flags(lane_bits)
    );

    // summary flag and status pin
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            summary_reg <= 1'b0;
            pin_reg <= 1'b0;
        end else begin
            summary_reg <= |(status_bits & ~mask_reg);
            pin_reg <= ctrl_reg[cam_pkg::CTL_PIN_SEL] ? summary_reg : calibration_status;
        end
    end

    // auto reinitialisation sequencing
    always_comb begin
        ri_state_next = ri_state_reg;
        case (ri_state_reg)
            cam_pkg::RI_IDLE: begin
                if (ctrl_reg[cam_pkg::CTL_AUTO_REINIT] && events[cam_pkg::BIT_FIFO]) begin
                    ri_state_next = cam_pkg::RI_HOLD;
                end
            end
            cam_pkg::RI_HOLD: begin
                if (ri_cnt_reg == cam_pkg::REINIT_CYCLES - 3'h1) begin
                    ri_state_next = cam_pkg::RI_RELEASE;
                end
            end
            default: begin
                ri_state_next = cam_pkg::RI_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ri_state_reg <= cam_pkg::RI_IDLE;
            ri_cnt_reg <= '0;
        end else begin
            ri_state_reg <= ri_state_next;
            ri_cnt_reg <= (ri_state_reg == cam_pkg::RI_HOLD) ? ri_cnt_reg + 3'h1 : 3'h0;
        end
    end

    // link reset, serializer power and clock gating
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            link_reset_n_reg <= 1'b0;
            ser_pd_reg <= 1'b1;
            link_clk_en_reg <= 1'b0;
            reinit_reg <= 1'b0;
        end else begin
            link_reset_n_reg <= link_en && (ri_state_next != cam_pkg::RI_HOLD);
            ser_pd_reg <= !link_en;
            link_clk_en_reg <= link_en;
            reinit_reg <= ri_state_next == cam_pkg::RI_HOLD;
        end
    end

    assign avs_readdata = readdata_reg;
    assign avs_waitrequest = waitrequest_reg;
    assign status_output_pin = pin_reg;
    assign link_reset_n = link_reset_n_reg;
    assign serializer_power_down = ser_pd_reg;
    assign link_clock_enable = link_clk_en_reg;
    assign link_reinit = reinit_reg;

    // checks
    sequence s_fifo_trigger;
        ri_state_reg == cam_pkg::RI_IDLE && ctrl_reg[cam_pkg::CTL_AUTO_REINIT]
            && events[cam_pkg::BIT_FIFO];
    endsequence

    sequence s_reinit_hold;
        (!link_reset_n && link_reinit) [*4] ##1 !link_reinit;
    endsequence

    chk_status_set: assert property (
        @(posedge clock) disable iff (!nrst)
        events[cam_pkg::BIT_SYSREF] |=> status_bits[cam_pkg::BIT_SYSREF])
        else $error("sysref alarm bit not set");

    chk_status_sticky: assert property (
        @(posedge clock) disable iff (!nrst)
        ##1 ((status_bits & $past(status_bits & ~status_clr)) == $past(status_bits & ~status_clr)))
        else $error("status bit dropped without clear");

    chk_summary_masked: assert property (
        @(posedge clock) disable iff (!nrst)
        ((status_bits & ~mask_reg) == '0) [*2] |-> !summary_reg)
        else $error("summary set by masked alarm");

    chk_pin_alarm: assert property (
        @(posedge clock) disable iff (!nrst)
        (ctrl_reg[cam_pkg::CTL_PIN_SEL] && |(status_bits & ~mask_reg)) [*2]
            |=> status_output_pin)
        else $error("status pin not high on alarm");

    chk_pll_alarm: assert property (
        @(posedge clock) disable iff (!nrst)
        !serdes_pll_locked |=> status_bits[cam_pkg::BIT_PLL])
        else $error("pll alarm missing");

    chk_link_alarm: assert property (
        @(posedge clock) disable iff (!nrst)
        link_en && !link_in_data_state |=> status_bits[cam_pkg::BIT_LINK])
        else $error("link alarm missing");

    chk_nco_mismatch: assert property (
        @(posedge clock) disable iff (!nrst)
        nco_synced_reg && both_on && chan_a_nco_acc != chan_b_nco_acc
            |=> ##1 status_bits[cam_pkg::BIT_NCO])
        else $error("oscillator mismatch not flagged");

    chk_nco_unsynced: assert property (
        @(posedge clock) disable iff (!nrst)
        !link_en |=> ##1 !nco_mismatch)
        else $error("oscillator check active before sync");

    chk_clk_mismatch: assert property (
        @(posedge clock) disable iff (!nrst)
        clk_cmp_en && chan_a_clocks != chan_b_clocks |=> ##1 status_bits[cam_pkg::BIT_CLK])
        else $error("clock mismatch not flagged");

    chk_lane_error: assert property (
        @(posedge clock) disable iff (!nrst)
        |lane_events |=> (lane_bits & $past(lane_events)) == $past(lane_events)
            && status_bits[cam_pkg::BIT_FIFO])
        else $error("lane fifo error not recorded");

    chk_reinit_run: assert property (
        @(posedge clock) disable iff (!nrst)
        s_fifo_trigger |=> s_reinit_hold)
        else $error("fifo error reinit sequence wrong");

    chk_link_off: assert property (
        @(posedge clock) disable iff (!nrst)
        !link_en |=> !link_reset_n && serializer_power_down && !link_clock_enable)
        else $error("disabled link not held off");

    chk_set_wins: assert property (
        @(posedge clock) disable iff (!nrst)
        events[cam_pkg::BIT_PLL] && status_clr[cam_pkg::BIT_PLL] |=> status_bits[cam_pkg::BIT_PLL])
        else $error("clear beat a same-cycle alarm");

    chk_bus_answer: assert property (
        @(posedge clock) disable iff (!nrst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after one wait cycle");
endmodule
`default_nettype wire

// ===== cam_monitor_test.sv
`timescale 1ns/100ps
`default_nettype none
module cam_monitor_test;
    // bus offsets, short names
    localparam logic [7:0] A_ST = cam_pkg::OFF_STATUS;
    localparam logic [7:0] A_LN = cam_pkg::OFF_LANE;
    localparam logic [7:0] A_MK = cam_pkg::OFF_MASK;
    localparam logic [7:0] A_SM = cam_pkg::OFF_SUMMARY;
    localparam logic [7:0] A_CT = cam_pkg::OFF_CTRL;
    // clock, reset and bus
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    // alarm sources
    logic [15:0] fifo_overflow_lane = 16'h0;
    logic [15:0] fifo_underflow_lane = 16'h0;
    logic serdes_pll_locked = 1'b1;
    logic link_in_data_state = 1'b1;
    logic sysref_realign = 1'b0;
    logic sysref_event = 1'b0;
    logic lane_align_start = 1'b0;
    logic power_down_pin = 1'b0;
    logic [31:0] chan_a_nco_acc = 32'h0;
    logic [31:0] chan_b_nco_acc = 32'h0;
    logic [3:0] chan_a_clocks = 4'h5;
    logic [3:0] chan_b_clocks = 4'h5;
    logic half_rate_tick = 1'b0;
    logic calibration_status = 1'b0;
    // outputs
    logic status_output_pin;
    logic link_reset_n;
    logic serializer_power_down;
    logic link_clock_enable;
    logic link_reinit;
    // bookkeeping
    int errors = 0;
    int checks = 0;
    logic [31:0] exp_q[$];
    logic [31:0] val;
    int lane;
    int unsigned pos[4] = '{cam_pkg::BIT_FIFO, cam_pkg::BIT_PLL, cam_pkg::BIT_LINK,
                            cam_pkg::BIT_SYSREF};

    cam_monitor #(.LANES(16), .NCO_W(32), .CLK_W(4)) i_cam_monitor (
        .clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .fifo_overflow_lane(fifo_overflow_lane),
        .fifo_underflow_lane(fifo_underflow_lane), .serdes_pll_locked(serdes_pll_locked),
        .link_in_data_state(link_in_data_state), .sysref_realign(sysref_realign),
        .sysref_event(sysref_event), .lane_align_start(lane_align_start),
        .power_down_pin(power_down_pin), .chan_a_nco_acc(chan_a_nco_acc),
        .chan_b_nco_acc(chan_b_nco_acc), .chan_a_clocks(chan_a_clocks),
        .chan_b_clocks(chan_b_clocks), .half_rate_tick(half_rate_tick),
        .calibration_status(calibration_status), .status_output_pin(status_output_pin),
        .link_reset_n(link_reset_n), .serializer_power_down(serializer_power_down),
        .link_clock_enable(link_clock_enable), .link_reinit(link_reinit)
    );

    // clock source
    always #50 clock = ~clock;

    // one comparison, counted
    function automatic void check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endfunction

    // verdict and end of run
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // read data watcher, oldest note first
    always @(posedge clock) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("mismatch at %0t got %h expected %h", $time, avs_readdata, 32'h0);
            end else begin
                val = exp_q.pop_front();
                check(avs_readdata, val);
            end
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // one avalon access, held until waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be, input logic [31:0] exp);
        int n;
        n = 0;
        @(posedge clock);
        if (!wr) exp_q.push_back(exp);
        avs_address <= a;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            n++;
            @(posedge clock);
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) begin
            errors++;
            end_sim();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf, exp);
    endtask

    // one-cycle channel clock difference, with or without strobe
    task automatic clk_glitch(input logic t);
        @(posedge clock);
        chan_b_clocks <= ~chan_a_clocks;
        half_rate_tick <= t;
        @(posedge clock);
        chan_b_clocks <= chan_a_clocks;
        half_rate_tick <= 1'b0;
        tick(4);
    endtask

    // one-cycle oscillator difference
    task automatic nco_glitch;
        @(posedge clock);
        chan_b_nco_acc <= chan_a_nco_acc ^ 32'h1;
        @(posedge clock);
        chan_b_nco_acc <= chan_a_nco_acc;
        tick(4);
    endtask

    // main sequence
    initial begin
        val = $urandom(16365);
        tick(6);
        nrst <= 1'b1;
        rd(A_ST, 32'h0);
        rd(A_LN, 32'h0);
        rd(A_MK, 32'h0);
        rd(A_CT, 32'h0);
        rd(8'h14, 32'h0);
        wr(A_SM, 32'hffffffff);
        rd(A_SM, 32'h0);
        $display("test reset finished");
        wr(A_CT, 32'h1);
        for (int k = 0; k < 4; k++) begin
            lane = $urandom_range(15, 0);
            @(posedge clock);
            case (k)
                0: fifo_overflow_lane <= 16'h1 << lane;
                1: serdes_pll_locked <= 1'b0;
                2: link_in_data_state <= 1'b0;
                default: sysref_realign <= 1'b1;
            endcase
            @(posedge clock);
            fifo_overflow_lane <= 16'h0;
            serdes_pll_locked <= 1'b1;
            link_in_data_state <= 1'b1;
            sysref_realign <= 1'b0;
            tick(4);
            rd(A_ST, 32'h1 << pos[k]);
            if (k == 0) rd(A_LN, 32'h1 << lane);
            bus(1'b1, A_ST, 32'hffffffff, 4'h0, 32'h0);
            wr(A_ST, 32'h0);
            rd(A_ST, 32'h1 << pos[k]);
            wr(A_ST, 32'h1 << pos[k]);
            wr(A_LN, 32'hffffffff);
            rd(A_ST, 32'h0);
        end
        $display("test sources finished");
        wr(A_CT, 32'h3);
        wr(A_MK, 32'h2);
        @(posedge clock);
        serdes_pll_locked <= 1'b0;
        @(posedge clock);
        serdes_pll_locked <= 1'b1;
        tick(4);
        rd(A_SM, 32'h0);
        check({31'h0, status_output_pin}, 32'h0);
        wr(A_MK, 32'h0);
        tick(3);
        rd(A_SM, 32'h1);
        check({31'h0, status_output_pin}, 32'h1);
        @(posedge clock);
        serdes_pll_locked <= 1'b0;
        wr(A_ST, 32'h2);
        rd(A_ST, 32'h2);
        @(posedge clock);
        serdes_pll_locked <= 1'b1;
        wr(A_ST, 32'h2);
        tick(3);
        check({31'h0, status_output_pin}, 32'h0);
        wr(A_CT, 32'h1);
        @(posedge clock);
        calibration_status <= 1'b1;
        tick(3);
        check({31'h0, status_output_pin}, 32'h1);
        $display("test summary finished");
        for (int s = 0; s < 2; s++) begin
            wr(A_CT, 32'h0);
            val = $urandom;
            chan_a_nco_acc <= val;
            chan_b_nco_acc <= val;
            wr(A_CT, 32'h1 | (s << 3));
            @(posedge clock);
            if (s == 1) sysref_event <= 1'b1;
            else lane_align_start <= 1'b1;
            @(posedge clock);
            sysref_event <= 1'b0;
            lane_align_start <= 1'b0;
            nco_glitch();
            rd(A_ST, 32'h0);
            @(posedge clock);
            if (s == 1) lane_align_start <= 1'b1;
            else sysref_event <= 1'b1;
            @(posedge clock);
            sysref_event <= 1'b0;
            lane_align_start <= 1'b0;
            nco_glitch();
            rd(A_ST, 32'h1 << cam_pkg::BIT_NCO);
            wr(A_ST, 32'h1 << cam_pkg::BIT_NCO);
            rd(A_ST, 32'h0);
        end
        $display("test oscillator finished");
        wr(A_CT, 32'h1);
        clk_glitch(1'b0);
        rd(A_ST, 32'h0);
        clk_glitch(1'b1);
        rd(A_ST, 32'h1 << cam_pkg::BIT_CLK);
        wr(A_ST, 32'h1 << cam_pkg::BIT_CLK);
        wr(A_CT, 32'h11);
        clk_glitch(1'b1);
        rd(A_ST, 32'h0);
        wr(A_CT, 32'h21);
        clk_glitch(1'b1);
        rd(A_ST, 32'h0);
        wr(A_CT, 32'h1);
        @(posedge clock);
        power_down_pin <= 1'b1;
        clk_glitch(1'b1);
        rd(A_ST, 32'h0);
        @(posedge clock);
        power_down_pin <= 1'b0;
        chan_b_clocks <= ~chan_a_clocks;
        half_rate_tick <= 1'b1;
        @(posedge clock);
        chan_b_clocks <= chan_a_clocks;
        half_rate_tick <= 1'b0;
        tick(4);
        rd(A_ST, 32'h1 << cam_pkg::BIT_CLK);
        wr(A_ST, 32'h1 << cam_pkg::BIT_CLK);
        rd(A_ST, 32'h0);
        $display("test clock finished");
        wr(A_CT, 32'h0);
        tick(2);
        check({29'h0, link_reset_n, serializer_power_down, link_clock_enable}, 32'h2);
        wr(A_CT, 32'h5);
        tick(2);
        check({29'h0, link_reset_n, serializer_power_down, link_clock_enable}, 32'h5);
        @(posedge clock);
        fifo_underflow_lane <= 16'h8000;
        @(posedge clock);
        fifo_underflow_lane <= 16'h0;
        repeat (4) begin
            @(posedge clock);
            check({30'h0, link_reinit, link_reset_n}, 32'h2);
        end
        @(posedge clock);
        check({30'h0, link_reinit, link_reset_n}, 32'h1);
        rd(A_LN, 32'h8000);
        rd(A_ST, 32'h1);
        $display("test reinit finished");
        end_sim();
    end
endmodule
`default_nettype wire
